/* File: verilog/msc_mission_status.sv */
`timescale 1ns/1ps
`include "msc_defs.svh"

module msc_mission_status #(
    parameter int WAKE_CYCLES = `MSC_WAKE_MS * `MSC_CLK_KHZ,
    parameter int CONV_MAX_CYCLES = `MSC_CONV_MAX_MS * `MSC_CLK_KHZ
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // register page access
    input msc_pkg::msc_req_s REQ,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    // control register bits and memory commands
    input wire logic MISSION_ENABLE_N,
    input wire logic CLEAR_MEM,
    input wire logic CMD_CONV,
    // real-time clock
    input msc_pkg::msc_rtc_s RTC,
    input wire logic MINUTE_TICK,
    input wire logic RTC_ALARM,
    // alarm thresholds
    input wire logic [7:0] LOW_THRESHOLD,
    input wire logic [7:0] HIGH_THRESHOLD,
    // conversion core
    output logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [7:0] CONV_RESULT,
    // live status
    output logic [7:0] STATUS
);
    import msc_pkg::*;

    localparam logic [25:0] WAKE_LAST = 26'(WAKE_CYCLES - 1);
    localparam logic [25:0] CONV_LAST = 26'(CONV_MAX_CYCLES - 1);

    // counters saturate instead of wrapping so a full count never reads small
    function automatic msc_count_t sat_inc(input msc_count_t value);
        sat_inc = (value == `MSC_CNT_MAX) ? value : value + 24'h000001;
    endfunction : sat_inc

    function automatic logic addr_is(input logic [15:0] addr, input logic [15:0] ref_addr);
        addr_is = (addr == ref_addr);
    endfunction : addr_is

    // a hit in the cycle of a clearing write still sets, so no event is lost
    function automatic logic flag_next(input logic hit, input logic flag, input logic wr0);
        flag_next = hit | (flag & ~wr0);
    endfunction : flag_next

    // state
    msc_state_e state_q, state_d;
    logic [25:0] timer_q, timer_d;
    logic [16:0] minutes_left_q, minutes_left_d;
    logic conv_mission_q, conv_mission_d;
    logic busy_n_q, busy_n_d;
    logic cleared_q, cleared_d;
    logic mission_q, mission_d;
    logic sampling_q, sampling_d;
    logic low_q, low_d;
    logic high_q, high_d;
    logic timer_alarm_q, timer_alarm_d;
    logic conv_start_q, conv_start_d;
    msc_rtc_s stamp_q, stamp_d;
    logic [7:0] rate_q, rate_d;
    logic [15:0] delay_q, delay_d;
    msc_count_t mission_cnt_q, mission_cnt_d;
    msc_count_t life_cnt_q, life_cnt_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic rd_valid_q;

    // access decode
    wire page_write = REQ.wr && (REQ.addr >= `MSC_ADDR_PAGE_FIRST)
        && (REQ.addr <= `MSC_ADDR_DELAY_HI);
    wire end_by_copy = mission_q && page_write;
    wire write_ok = REQ.wr && !end_by_copy; // first attempt is swallowed
    wire rate_wr = write_ok && addr_is(REQ.addr, `MSC_ADDR_RATE);
    wire delay_lo_wr = write_ok && addr_is(REQ.addr, `MSC_ADDR_DELAY_LO);
    wire delay_hi_wr = write_ok && addr_is(REQ.addr, `MSC_ADDR_DELAY_HI);
    wire status_wr = REQ.wr && addr_is(REQ.addr, `MSC_ADDR_STATUS);

    // mission start needs non-zero rate, enable bit low and cleared memory
    wire start_mission = rate_wr && (REQ.wdata != 8'h00) && !MISSION_ENABLE_N
        && cleared_q;

    // clearing while a mission or conversion runs would tear the bookkeeping
    wire clear_req = CLEAR_MEM && !mission_q && (state_q == ST_IDLE);

    // host write of 0 to a clear-only bit
    wire mission_wr0 = status_wr && !REQ.wdata[`MSC_BIT_MISSION];
    wire low_wr0 = status_wr && !REQ.wdata[`MSC_BIT_LOW];
    wire high_wr0 = status_wr && !REQ.wdata[`MSC_BIT_HIGH];
    wire timer_wr0 = status_wr && !REQ.wdata[`MSC_BIT_TIMER];

    // minute scheduling: a sample falls due on the tick that empties the count
    wire mission_tick = mission_q && MINUTE_TICK;
    wire sample_due = mission_tick && (minutes_left_q == `MSC_MIN_ONE);
    wire launch_mission = sample_due && (state_q == ST_IDLE);
    wire launch_cmd = CMD_CONV && !mission_q && (state_q == ST_IDLE);
    wire wake_over = (state_q == ST_WAKE) && (timer_q == WAKE_LAST);
    wire enter_conv = wake_over || launch_cmd;
    wire conv_timeout = (state_q == ST_CONV) && (timer_q == CONV_LAST);
    wire result_ok = (state_q == ST_CONV) && CONV_DONE;
    wire conv_finish = result_ok || conv_timeout;
    wire mission_result = result_ok && conv_mission_q;
    wire low_hit = mission_result && (CONV_RESULT <= LOW_THRESHOLD);
    wire high_hit = mission_result && (CONV_RESULT >= HIGH_THRESHOLD);
    wire [16:0] first_wait = {9'h000, REQ.wdata} + {1'b0, delay_q};

    // conversion sequencer: wake phase for mission samples, then the core
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (launch_mission) begin
                    state_d = ST_WAKE;
                end else if (launch_cmd) begin
                    state_d = ST_CONV;
                end
            end
            ST_WAKE: begin
                if (wake_over) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_finish) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // one timer spans wake and conversion, so the whole sample is bounded
    assign timer_d = (launch_mission || launch_cmd || conv_finish) ? 26'h0000000
        : (state_q == ST_IDLE) ? timer_q : timer_q + 26'h0000001;
    assign conv_mission_d = launch_mission ? 1'b1 : launch_cmd ? 1'b0 : conv_mission_q;
    assign conv_start_d = enter_conv;

    // busy is low from the start pulse until the result is latched or the timer bound ends the conversion
    assign busy_n_d = enter_conv ? 1'b0 : conv_finish ? 1'b1 : busy_n_q;

    // sampling covers the wake phase and the mission conversion
    assign sampling_d = launch_mission ? 1'b1
        : (conv_finish && conv_mission_q) ? 1'b0 : sampling_q;

    // minute countdown: rate plus delay first, then rate for each later sample
    assign minutes_left_d = start_mission ? first_wait
        : sample_due ? {9'h000, rate_q}
        : mission_tick ? minutes_left_q - `MSC_MIN_ONE : minutes_left_q;

    // mission flag: set only by starting, cleared by copy write or host zero
    assign mission_d = start_mission ? 1'b1
        : (end_by_copy || mission_wr0) ? 1'b0 : mission_q;

    // memory cleared flag
    assign cleared_d = clear_req ? 1'b1
        : start_mission ? 1'b0 : cleared_q;

    // alarm flags: set by their event, cleared only by a zero write
    assign low_d = flag_next(low_hit, low_q, low_wr0);
    assign high_d = flag_next(high_hit, high_q, high_wr0);
    assign timer_alarm_d = flag_next(RTC_ALARM, timer_alarm_q, timer_wr0);

    // time stamp captured on start, zeroed by clear
    assign stamp_d = clear_req ? '0 : start_mission ? RTC : stamp_q;

    // sample rate and start delay storage
    assign rate_d = clear_req ? 8'h00 : rate_wr ? REQ.wdata : rate_q;
    assign delay_d = clear_req ? 16'h0000
        : delay_lo_wr ? {delay_q[15:8], REQ.wdata}
        : delay_hi_wr ? {REQ.wdata, delay_q[7:0]} : delay_q;

    // sample counters; the mission count holds after the mission and any sample it started have ended
    assign mission_cnt_d = clear_req ? 24'h000000
        : mission_result ? sat_inc(mission_cnt_q) : mission_cnt_q;
    assign life_cnt_d = result_ok ? sat_inc(life_cnt_q) : life_cnt_q;

    // live status byte; the read path and the output share one packing
    wire [7:0] status_now = {busy_n_q, cleared_q, mission_q, sampling_q,
        1'b0, low_q, high_q, timer_alarm_q};

    // read path; pages 17 and up are never blocked here while a sample runs
    always_comb begin
        case (REQ.addr)
            `MSC_ADDR_RATE: rd_data_d = rate_q;
            `MSC_ADDR_DELAY_LO: rd_data_d = delay_q[7:0];
            `MSC_ADDR_DELAY_HI: rd_data_d = delay_q[15:8];
            `MSC_ADDR_STATUS: rd_data_d = status_now;
            `MSC_ADDR_STAMP_MIN: rd_data_d = stamp_q.minutes;
            `MSC_ADDR_STAMP_HOUR: rd_data_d = stamp_q.hours;
            `MSC_ADDR_STAMP_DATE: rd_data_d = stamp_q.date;
            `MSC_ADDR_STAMP_MONTH: rd_data_d = stamp_q.month;
            `MSC_ADDR_STAMP_YEAR: rd_data_d = stamp_q.year;
            `MSC_ADDR_MCNT_LO: rd_data_d = mission_cnt_q[7:0];
            `MSC_ADDR_MCNT_MID: rd_data_d = mission_cnt_q[15:8];
            `MSC_ADDR_MCNT_HI: rd_data_d = mission_cnt_q[23:16];
            `MSC_ADDR_LCNT_LO: rd_data_d = life_cnt_q[7:0];
            `MSC_ADDR_LCNT_MID: rd_data_d = life_cnt_q[15:8];
            `MSC_ADDR_LCNT_HI: rd_data_d = life_cnt_q[23:16];
            default: rd_data_d = 8'h00;
        endcase
    end

    // sequencer state
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // sample timer, shared by wake and conversion so one bound covers both
    always_ff @(posedge CLK) begin
        if (SRST) begin
            timer_q <= 26'h0000000;
        end else begin
            timer_q <= timer_d;
        end
    end

    // remembers whether the running conversion belongs to the mission
    always_ff @(posedge CLK) begin
        if (SRST) begin
            conv_mission_q <= 1'b0;
        end else begin
            conv_mission_q <= conv_mission_d;
        end
    end

    // start pulse to the core, one cycle wide
    always_ff @(posedge CLK) begin
        if (SRST) begin
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= conv_start_d;
        end
    end

    // core busy, active low; idles high after reset
    always_ff @(posedge CLK) begin
        if (SRST) begin
            busy_n_q <= 1'b1;
        end else begin
            busy_n_q <= busy_n_d;
        end
    end

    // sampling flag for mission conversions only
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sampling_q <= 1'b0;
        end else begin
            sampling_q <= sampling_d;
        end
    end

    // minutes until the next mission sample
    always_ff @(posedge CLK) begin
        if (SRST) begin
            minutes_left_q <= 17'h00000;
        end else begin
            minutes_left_q <= minutes_left_d;
        end
    end

    // mission active flag
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mission_q <= 1'b0;
        end else begin
            mission_q <= mission_d;
        end
    end

    // memory cleared; low after reset so a clear must precede the first mission
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cleared_q <= 1'b0;
        end else begin
            cleared_q <= cleared_d;
        end
    end

    // low temperature alarm flag
    always_ff @(posedge CLK) begin
        if (SRST) begin
            low_q <= 1'b0;
        end else begin
            low_q <= low_d;
        end
    end

    // high temperature alarm flag
    always_ff @(posedge CLK) begin
        if (SRST) begin
            high_q <= 1'b0;
        end else begin
            high_q <= high_d;
        end
    end

    // clock alarm flag; may set outside a mission too
    always_ff @(posedge CLK) begin
        if (SRST) begin
            timer_alarm_q <= 1'b0;
        end else begin
            timer_alarm_q <= timer_alarm_d;
        end
    end

    // mission time stamp
    always_ff @(posedge CLK) begin
        if (SRST) begin
            stamp_q <= '0;
        end else begin
            stamp_q <= stamp_d;
        end
    end

    // sample rate in minutes
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rate_q <= 8'h00;
        end else begin
            rate_q <= rate_d;
        end
    end

    // start delay in minutes
    always_ff @(posedge CLK) begin
        if (SRST) begin
            delay_q <= 16'h0000;
        end else begin
            delay_q <= delay_d;
        end
    end

    // mission sample count
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mission_cnt_q <= 24'h000000;
        end else begin
            mission_cnt_q <= mission_cnt_d;
        end
    end

    // lifetime count; only the reset pin clears it, software cannot
    always_ff @(posedge CLK) begin
        if (SRST) begin
            life_cnt_q <= 24'h000000;
        end else begin
            life_cnt_q <= life_cnt_d;
        end
    end

    // read answer one cycle after the request
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q <= REQ.rd ? rd_data_d : rd_data_q;
            rd_valid_q <= REQ.rd;
        end
    end

    assign RD_DATA = rd_data_q;
    assign RD_VALID = rd_valid_q;
    assign CONV_START = conv_start_q;
    assign STATUS = status_now;

endmodule : msc_mission_status

/* File: verilog/msc_defs.svh */
// Notes on behaviour
// - status byte: busy b7, cleared b6, mission b5, sampling b4, alarms b2..b0
// - mission and all three alarm bits only clear on write; others ignore writes
// - busy bit reads 0 during any conversion, mission or command started
// - busy drops with the conversion start pulse, returns after result is latched or on timeout
// - cleared bit reads 1 after clear-memory zeroed stamp, counter, delay, rate
// - cleared bit returns 0 when a non-zero rate write starts a mission
// - mission start refused unless memory has been cleared
// - non-zero rate write with mission-enable bit 0 starts mission
// - first register-page write 200h..213h during a mission ends it
// - host may end mission by writing 0; status write never sets it
// - sampling bit rises about 250 ms before each mission conversion
// - mission conversion with wake-up lasts at most 875 ms; reads allowed
// - low alarm set at or below low threshold; write 0 clears
// - high alarm set at or above high threshold; write 0 clears
// - timer alarm set on every clock alarm; write 0 clears
// - mission start copies clock minutes..year into stamp bytes at 0215h
// - first sample after rate plus delay minutes, then every rate minutes
// - 24-bit mission sample count, low byte first; clear-memory resets it
// - 24-bit lifetime count, max 16777215, never reset by software
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

// register page addresses
`define MSC_ADDR_PAGE_FIRST 16'h0200
`define MSC_ADDR_RATE 16'h020d
`define MSC_ADDR_DELAY_LO 16'h0212
`define MSC_ADDR_DELAY_HI 16'h0213
`define MSC_ADDR_STATUS 16'h0214
`define MSC_ADDR_STAMP_MIN 16'h0215
`define MSC_ADDR_STAMP_HOUR 16'h0216
`define MSC_ADDR_STAMP_DATE 16'h0217
`define MSC_ADDR_STAMP_MONTH 16'h0218
`define MSC_ADDR_STAMP_YEAR 16'h0219
`define MSC_ADDR_MCNT_LO 16'h021a
`define MSC_ADDR_MCNT_MID 16'h021b
`define MSC_ADDR_MCNT_HI 16'h021c
`define MSC_ADDR_LCNT_LO 16'h021d
`define MSC_ADDR_LCNT_MID 16'h021e
`define MSC_ADDR_LCNT_HI 16'h021f

// status bit positions
`define MSC_BIT_BUSY_N 7
`define MSC_BIT_CLEARED 6
`define MSC_BIT_MISSION 5
`define MSC_BIT_SAMPLING 4
`define MSC_BIT_LOW 2
`define MSC_BIT_HIGH 1
`define MSC_BIT_TIMER 0

// counters and timing
`define MSC_CNT_MAX 24'hffffff
`define MSC_MIN_ONE 17'h00001
`define MSC_CLK_KHZ 50000
`define MSC_WAKE_MS 250
`define MSC_CONV_MAX_MS 875

`endif

/* File: verilog/msc_pkg.sv */
package msc_pkg;

    // one register page access from the link command engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } msc_req_s;

    // live clock registers, packed decimal as the clock keeps them
    typedef struct packed {
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } msc_rtc_s;

    typedef logic [23:0] msc_count_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAKE = 2'b01,
        ST_CONV = 2'b10
    } msc_state_e;

endpackage : msc_pkg

/* File: verification/msc_status_monitor.sv */
`timescale 1ns/1ps

module msc_status_monitor #(
    parameter int WAKE_CYCLES = 10
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // watched inputs
    input msc_pkg::msc_req_s REQ,
    input wire logic MISSION_ENABLE_N,
    input wire logic CLEAR_MEM,
    input wire logic RTC_ALARM,
    input wire logic [7:0] LOW_THRESHOLD,
    input wire logic CONV_DONE,
    input wire logic [7:0] CONV_RESULT,
    // watched outputs
    input wire logic CONV_START,
    input wire logic [7:0] STATUS
);
    import msc_pkg::*;
    // one cycle of slack either side, the wake count edge is loosely specified
    localparam int WAKE_LO = WAKE_CYCLES - 1;
    localparam int WAKE_HI = WAKE_CYCLES + 1;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // decoded write kinds
    wire logic wr_stat = REQ.wr && REQ.addr == 16'h0214;
    wire logic wr_rate = REQ.wr && REQ.addr == 16'h020d && REQ.wdata != 8'h00 && !MISSION_ENABLE_N;
    wire logic wr_page = REQ.wr && REQ.addr >= 16'h0200 && REQ.addr <= 16'h0213;

    a_bit_three_zero: assert property (!STATUS[3]) else $error("status bit 3 set");
    a_no_mission_set: assert property (wr_stat && !STATUS[5] |=> !STATUS[5])
        else $error("status write set mission bit");
    a_mission_clear: assert property (wr_stat && !REQ.wdata[5] |=> !STATUS[5])
        else $error("mission bit not cleared by write");
    a_busy_on_start: assert property (CONV_START |-> !STATUS[7])
        else $error("busy not low at conversion start");
    a_busy_release: assert property (CONV_DONE && !STATUS[7] |=> STATUS[7])
        else $error("busy not released after result");
    a_mission_start: assert property (wr_rate && STATUS[6]
        |=> STATUS[5] && !STATUS[6]) else $error("mission did not start");
    a_start_refused: assert property (wr_rate && STATUS[6:5] == 2'h0 |=> !STATUS[5])
        else $error("mission started without clear");
    a_end_by_write: assert property (wr_page && STATUS[5] |=> !STATUS[5])
        else $error("page write did not end mission");
    a_clear_sets: assert property (CLEAR_MEM && STATUS[7] && STATUS[5:4] == 2'h0
        |=> STATUS[6]) else $error("cleared bit not set");
    a_timer_flag: assert property (RTC_ALARM |=> STATUS[0])
        else $error("timer flag missed");
    a_low_alarm: assert property (CONV_DONE && STATUS[4]
        && CONV_RESULT <= LOW_THRESHOLD |=> STATUS[2]) else $error("low flag missed");
    a_wake_lead: assert property ($rose(STATUS[4]) |-> ##[WAKE_LO:WAKE_HI] CONV_START)
        else $error("wake phase length wrong");
endmodule : msc_status_monitor

bind msc_mission_status msc_status_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) u_mon (
    .CLK(CLK), .SRST(SRST), .REQ(REQ), .MISSION_ENABLE_N(MISSION_ENABLE_N),
    .CLEAR_MEM(CLEAR_MEM), .RTC_ALARM(RTC_ALARM), .LOW_THRESHOLD(LOW_THRESHOLD),
    .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT), .CONV_START(CONV_START),
    .STATUS(STATUS)
);

/* File: verification/msc_host_model.sv */
`timescale 1ns/1ps

module msc_host_model (
    // clock
    input wire logic CLK,
    // register page access
    output msc_pkg::msc_req_s REQ,
    input wire logic [7:0] RD_DATA,
    input wire logic RD_VALID,
    // control bit
    output logic MISSION_ENABLE_N
);
    import msc_pkg::*;
    // idle bus; enable kept low so missions may start
    initial begin
        REQ = '0;
        MISSION_ENABLE_N = 1'h0;
    end
    // one write strobe; address and data inverted afterwards so stale values are not trusted
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK) #1;
        REQ = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge CLK) #1;
        REQ = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
    endtask : wr
    // control bit change, made off the sampling edge like any request
    task automatic set_enable_n(input logic v);
        @(posedge CLK) #1;
        MISSION_ENABLE_N = v;
    endtask : set_enable_n
    // one read strobe, answer awaited for a bounded time
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge CLK) #1;
        REQ = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge CLK) #1;
        REQ = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hff};
        for (int i = 0; i < 3 && RD_VALID !== 1'h1; i++) @(posedge CLK) #1;
        d = RD_VALID === 1'h1 ? RD_DATA : 8'hxx;
    endtask : rd
endmodule : msc_host_model

/* File: verification/test_mission_status_counters.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end

module test_mission_status_counters;
    import msc_pkg::*;
    logic CLK = 1'h0;
    logic SRST = 1'h1;
    msc_req_s REQ;
    logic [7:0] RD_DATA, STATUS, got;
    logic RD_VALID, MISSION_ENABLE_N, CONV_START;
    logic CLEAR_MEM = 1'h0, CMD_CONV = 1'h0, MINUTE_TICK = 1'h0, RTC_ALARM = 1'h0;
    logic CONV_DONE = 1'h0;
    logic [7:0] CONV_RESULT = 8'h00, LOW_THRESHOLD = 8'h0a, HIGH_THRESHOLD = 8'h14;
    msc_rtc_s RTC = '{minutes: 8'h59, hours: 8'h23, date: 8'h31, month: 8'h12, year: 8'h99};
    logic [23:0] cnt;
    int fails = 0;
    int check_count = 0;

    // short wake and timeout counts keep the run brief
    msc_mission_status #(.WAKE_CYCLES(10), .CONV_MAX_CYCLES(40)) dut (
        .CLK(CLK), .SRST(SRST), .REQ(REQ), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
        .MISSION_ENABLE_N(MISSION_ENABLE_N), .CLEAR_MEM(CLEAR_MEM), .CMD_CONV(CMD_CONV),
        .RTC(RTC), .MINUTE_TICK(MINUTE_TICK), .RTC_ALARM(RTC_ALARM),
        .LOW_THRESHOLD(LOW_THRESHOLD), .HIGH_THRESHOLD(HIGH_THRESHOLD),
        .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
        .STATUS(STATUS)
    );
    msc_host_model host (
        .CLK(CLK), .REQ(REQ), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
        .MISSION_ENABLE_N(MISSION_ENABLE_N)
    );

    always #10 CLK = ~CLK;

    task automatic wrap_up;
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    // one-cycle pulse on a command input
    task automatic pulse(ref logic s);
        @(posedge CLK) #1;
        s = 1'h1;
        @(posedge CLK) #1;
        s = 1'h0;
    endtask : pulse
    task automatic tick(input int n);
        repeat (n) pulse(MINUTE_TICK);
    endtask : tick
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        host.rd(a, got);
        `CHK(got, e)
    endtask : rd_chk
    task automatic rd24(input logic [15:0] a, output logic [23:0] v);
        host.rd(a, v[7:0]);
        host.rd(a + 16'h1, v[15:8]);
        host.rd(a + 16'h2, v[23:16]);
    endtask : rd24
    // conversion core side: wait for the start pulse, then answer late
    task automatic wait_start;
        for (int i = 0; i < 60 && CONV_START !== 1'h1; i++) @(posedge CLK) #1;
        `CHK(CONV_START, 1'h1)
    endtask : wait_start
    task automatic done(input logic [7:0] r);
        repeat (2) @(posedge CLK);
        #1;
        CONV_RESULT = r;
        CONV_DONE = 1'h1;
        @(posedge CLK) #1;
        CONV_DONE = 1'h0;
        CONV_RESULT = ~r;
    endtask : done

    // no mission before a clear; status writes set nothing
    task automatic t_refuse;
        rd_chk(16'h0214, 8'h80);
        host.wr(16'h020d, 8'h01);
        rd_chk(16'h0214, 8'h80);
        host.wr(16'h0214, 8'hff);
        rd_chk(16'h0214, 8'h80);
    endtask : t_refuse
    // full mission: stamp, first sample timing, both alarms, counter
    task automatic t_mission;
        pulse(CLEAR_MEM);
        rd_chk(16'h0214, 8'hc0);
        host.wr(16'h0212, 8'h01);
        host.wr(16'h020d, 8'h02);
        rd_chk(16'h0214, 8'ha0);
        for (int i = 0; i < 5; i++) rd_chk(16'h0215 + 16'(i), RTC[39 - 8 * i -: 8]);
        tick(2);
        rd_chk(16'h0214, 8'ha0);
        tick(1);
        rd_chk(16'h0214, 8'hb0);
        wait_start;
        rd_chk(16'h0214, 8'h30);
        done(8'h0a);
        rd_chk(16'h0214, 8'ha4);
        tick(2);
        wait_start;
        done(8'h14);
        rd_chk(16'h0214, 8'ha6);
        rd24(16'h021a, cnt);
        `CHK(cnt, 24'h000002)
    endtask : t_mission
    // timer flag, clearing writes, end by page write, counter clearing
    task automatic t_alarms;
        pulse(RTC_ALARM);
        rd_chk(16'h0214, 8'ha7);
        host.wr(16'h0214, 8'h00);
        rd_chk(16'h0214, 8'h80);
        rd24(16'h021a, cnt);
        `CHK(cnt, 24'h000002)
        pulse(CLEAR_MEM);
        host.wr(16'h020d, 8'h01);
        rd_chk(16'h0214, 8'ha0);
        host.wr(16'h020e, 8'h55);
        rd_chk(16'h0214, 8'h80);
        rd24(16'h021a, cnt);
        `CHK(cnt, 24'h000000)
        rd24(16'h021d, cnt);
        `CHK(cnt, 24'h000002)
    endtask : t_alarms
    // command conversion outside a mission
    task automatic t_cmd;
        pulse(CMD_CONV);
        wait_start;
        rd_chk(16'h0214, 8'h00);
        done(8'h50);
        rd_chk(16'h0214, 8'h80);
        rd24(16'h021d, cnt);
        `CHK(cnt, 24'h000003)
        // no answer from the core: busy must give up after the bound, uncounted
        pulse(CMD_CONV);
        wait_start;
        repeat (38) @(posedge CLK);
        #1;
        `CHK(STATUS, 8'h00)
        repeat (2) @(posedge CLK);
        #1;
        `CHK(STATUS, 8'h80)
        rd24(16'h021d, cnt);
        `CHK(cnt, 24'h000003)
    endtask : t_cmd
    // enable bit high blocks a start even with memory cleared
    task automatic t_enable;
        pulse(CLEAR_MEM);
        host.set_enable_n(1'h1);
        host.wr(16'h020d, 8'h01);
        rd_chk(16'h0214, 8'hc0);
        host.set_enable_n(1'h0);
        host.wr(16'h020d, 8'h01);
        rd_chk(16'h0214, 8'ha0);
    endtask : t_enable

    initial begin
        repeat (10) @(posedge CLK);
        #1;
        SRST = 1'h0;
        t_refuse;
        t_mission;
        t_alarms;
        t_cmd;
        t_enable;
        wrap_up;
    end
    // the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        wrap_up;
    end
endmodule : test_mission_status_counters
